// file: rtl/bridge_parity.sv
`timescale 1ns/1ps
// How it works
// - Check and generate parity on both buses
// - Forward queued parity condition unchanged
// - Address error, response off: claim, flag, forward
// - Primary address error, response on: refuse, system error
// - Secondary address error, response on: refuse, system error
// - Downstream posted write error: flag, forward, report
// - Upstream posted write target error raises secondary system error
// - Upstream write target error sets primary data parity detected bit
// - Downstream delayed write, response off: forward bad
// - Downstream delayed write, response on: drop, report
// - Upstream delayed write error reported at secondary ready
// - Upstream delayed read returns bad parity, flags
// - Config write error still writes, flags, reports
// - Config read returns data, no parity action
// - Parity error pin two clocks after data
// - Pin held high after the low until one clock after done, then released
// - System error only when its enable set
module bridge_parity (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // Register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [31:0]                 reg_rdata,
  output logic                             irq,
  // Primary bus sampling
  input  wire logic [31:0]                 p_ad,
  input  wire logic [3:0]                  p_cbe_n,
  input  wire logic                        p_par,
  input  wire logic                        p_addr_valid,
  input  wire logic                        p_hit,
  input  wire logic                        p_data_valid,
  input  wire bridge_parity_pkg::kind_t    p_kind,
  input  wire logic                        p_multi,
  input  wire logic                        p_txn_done,
  input  wire logic                        p_us_posted,
  input  wire logic                        p_us_delayed,
  input  wire logic                        p_perr_n_i,
  // Secondary bus sampling
  input  wire logic [31:0]                 s_ad,
  input  wire logic [3:0]                  s_cbe_n,
  input  wire logic                        s_par,
  input  wire logic                        s_addr_valid,
  input  wire logic                        s_hit,
  input  wire logic                        s_txn_done,
  input  wire logic                        s_trdy_ret,
  input  wire logic                        s_err_seen,
  // Outgoing parity generation
  input  wire logic [31:0]                 p_gen_ad,
  input  wire logic [3:0]                  p_gen_cbe_n,
  input  wire logic                        p_gen_bad,
  input  wire logic [31:0]                 s_gen_ad,
  input  wire logic [3:0]                  s_gen_cbe_n,
  input  wire logic                        s_gen_bad,
  output logic                             p_par_out,
  output logic                             s_par_out,
  // Decisions toward the target and queue logic
  output logic                             p_claim,
  output logic                             s_claim,
  output logic                             p_chk_valid,
  output logic                             p_chk_bad,
  output logic                             p_drop,
  output logic                             p_stop_req,
  // Error pins
  output logic                             p_perr_n_o,
  output logic                             p_perr_n_oe,
  output logic                             s_perr_n_o,
  output logic                             s_perr_n_oe,
  output logic                             p_serr_n_o,
  output logic                             p_serr_n_oe,
  output logic                             s_serr_n_o,
  output logic                             s_serr_n_oe
);

  bridge_parity_pkg::state_t st;       // Registered state
  bridge_parity_pkg::state_t next_st;  // Next state

  logic [1:0] resp;        // Parity response enables per bus
  logic [1:0] serr_en;     // System error enables per bus
  logic [1:0] a_err;       // Address parity error per bus
  logic [1:0] a_par_in;    // Sampled address parity bits
  logic [1:0] a_pend_in;   // New address phases
  logic [1:0] a_hit_in;    // Decode hits
  logic [1:0] a_calc;      // Parity of the new address phases
  logic [1:0] done;        // Transaction completions
  logic [1:0] perr_req;    // Request to drive the error pin low
  logic       d_err;       // Primary data parity error
  logic       d_checked;   // Class is checked by this device
  logic       tgt_perr;    // Primary target reported an error
  logic [6:0] st_set;      // Status events this cycle

  assign resp    = {st.ctrl[bridge_parity_pkg::S_RESP_BIT], st.ctrl[bridge_parity_pkg::P_RESP_BIT]};
  assign serr_en = {st.ctrl[bridge_parity_pkg::S_SERR_BIT], st.ctrl[bridge_parity_pkg::P_SERR_BIT]};
  assign a_par_in  = {s_par, p_par};
  assign a_pend_in = {s_addr_valid, p_addr_valid};
  assign a_hit_in  = {s_hit, p_hit};
  assign done      = {s_txn_done, p_txn_done};
  // Even parity over address and command lanes
  assign a_calc    = {^{s_ad, s_cbe_n}, ^{p_ad, p_cbe_n}};

  // Parity follows its data by one clock, so the check uses the stored sum
  assign a_err = st.a_pend & (st.a_par ^ a_par_in);
  assign d_err = st.d_pend & (st.d_par ^ p_par);
  // Reads that this device supplies are the initiator's job to check
  assign d_checked = st.d_kind inside {bridge_parity_pkg::DS_POSTED_WR,
                                       bridge_parity_pkg::DS_DELAYED_WR,
                                       bridge_parity_pkg::US_DELAYED_RD,
                                       bridge_parity_pkg::CFG_WR};
  // Target error seen while mastering an upstream write
  assign tgt_perr = !p_perr_n_i && (p_us_posted || p_us_delayed);

  // Error pin requests per bus
  always_comb begin
    perr_req[0] = d_err && d_checked && resp[0];
    perr_req[1] = st.s_perr_pend && s_trdy_ret;
  end

  // Status events; address errors flag either way
  always_comb begin
    st_set = '0;
    st_set[bridge_parity_pkg::ST_P_DET] = a_err[0] || (d_err && d_checked);
    st_set[bridge_parity_pkg::ST_S_DET] = a_err[1];
    st_set[bridge_parity_pkg::ST_P_DPD] = (tgt_perr && resp[0]) ||
      (d_err && st.d_kind == bridge_parity_pkg::US_DELAYED_RD && resp[0]);
    st_set[bridge_parity_pkg::ST_P_SERR] = next_st.serr[0];
    st_set[bridge_parity_pkg::ST_S_SERR] = next_st.serr[1];
    st_set[bridge_parity_pkg::ST_P_PERR] = perr_req[0];
    st_set[bridge_parity_pkg::ST_S_PERR] = perr_req[1];
  end

  // Next state
  always_comb begin
    next_st = st;
    // Register writes
    if (reg_write && reg_addr == bridge_parity_pkg::CTRL_OFS) begin
      next_st.ctrl = reg_wdata[3:0];
    end
    if (reg_write && reg_addr == bridge_parity_pkg::MASK_OFS) begin
      next_st.mask = reg_wdata[6:0];
    end
    // Read data stands only in the cycle after the strobe
    next_st.rdata = '0;
    if (reg_read) begin
      unique case (reg_addr)
        bridge_parity_pkg::CTRL_OFS:   next_st.rdata = {28'h0000000, st.ctrl};
        bridge_parity_pkg::STATUS_OFS: next_st.rdata = {25'h0000000, st.status};
        bridge_parity_pkg::MASK_OFS:   next_st.rdata = {25'h0000000, st.mask};
        default:                       next_st.rdata = '0;
      endcase
    end
    // Address stage: hold the sum until the parity bit arrives
    next_st.a_pend = a_pend_in;
    next_st.a_hit  = a_hit_in;
    next_st.a_par  = a_calc;
    // Refuse a bad address only when response is enabled
    next_st.claim = st.a_pend & st.a_hit & ~(a_err & resp);
    // System error only with its enable bit
    next_st.serr = a_err & resp & serr_en;
    // Upstream posted write: report toward the secondary side
    if (tgt_perr && p_us_posted && resp[0] && resp[1] && !s_err_seen && serr_en[1]) begin
      next_st.serr[1] = 1'b1;
    end
    // Primary data stage
    next_st.d_pend  = p_data_valid;
    next_st.d_par   = ^{p_ad, p_cbe_n};
    next_st.d_kind  = p_kind;
    next_st.d_multi = p_multi;
    next_st.chk_valid = st.d_pend && d_checked;
    // Queued condition is exactly what arrived
    next_st.chk_bad   = d_err && d_checked;
    // Delayed write is dropped only with response on
    next_st.drop = d_err && resp[0] && st.d_kind == bridge_parity_pkg::DS_DELAYED_WR;
    next_st.stop_req = next_st.drop && st.d_multi;
    // Upstream delayed write error waits for the secondary ready
    if (tgt_perr && p_us_delayed && resp[0] && resp[1]) begin
      next_st.s_perr_pend = 1'b1;
    end else if (s_trdy_ret) begin
      next_st.s_perr_pend = 1'b0;
    end
    // Error pins: low one clock, held high, parked high one clock after done
    for (int b = 0; b < 2; b++) begin
      next_st.perr_low[b]  = perr_req[b];
      next_st.perr_park[b] = done[b] && (st.perr_oe[b] || perr_req[b]);
      next_st.perr_oe[b]   = perr_req[b] || (st.perr_oe[b] && !st.perr_park[b]) ||
                             next_st.perr_park[b];
    end
    // Outgoing parity a clock after its data, bad kept bad
    next_st.par_out = {^{s_gen_ad, s_gen_cbe_n} ^ s_gen_bad,
                       ^{p_gen_ad, p_gen_cbe_n} ^ p_gen_bad};
    // Sticky status: a new event beats a clear in the same cycle
    if (reg_write && reg_addr == bridge_parity_pkg::STATUS_OFS) begin
      next_st.status = st.status & ~reg_wdata[6:0];
    end
    next_st.status = next_st.status | st_set;
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.ctrl   <= bridge_parity_pkg::CTRL_RESET;
      st.status <= bridge_parity_pkg::STATUS_RESET;
      st.mask   <= bridge_parity_pkg::MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops; irq ORs the masked status flops
  assign reg_rdata   = st.rdata;
  assign irq         = |(st.status & st.mask);
  assign p_claim     = st.claim[0];
  assign s_claim     = st.claim[1];
  assign p_chk_valid = st.chk_valid;
  assign p_chk_bad   = st.chk_bad;
  assign p_drop      = st.drop;
  assign p_stop_req  = st.stop_req;
  assign p_par_out   = st.par_out[0];
  assign s_par_out   = st.par_out[1];
  assign p_perr_n_o  = !st.perr_low[0];
  assign s_perr_n_o  = !st.perr_low[1];
  assign p_perr_n_oe = st.perr_oe[0];
  assign s_perr_n_oe = st.perr_oe[1];
  // Open drain: only ever pulls low
  assign p_serr_n_o  = 1'b0;
  assign s_serr_n_o  = 1'b0;
  assign p_serr_n_oe = st.serr[0];
  assign s_serr_n_oe = st.serr[1];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Bad primary data phase: data, then parity
  sequence bad_data_s;
    p_data_valid && p_kind == bridge_parity_pkg::CFG_WR &&
      st.ctrl[bridge_parity_pkg::P_RESP_BIT] ##1 (p_par != st.d_par);
  endsequence

  // Bad primary address phase with response on
  sequence bad_addr_s;
    p_addr_valid && p_hit && st.ctrl[bridge_parity_pkg::P_RESP_BIT] ##1 (p_par != st.a_par[0]);
  endsequence

  a_perr_two_clk: assert property (bad_data_s |=> !p_perr_n_o && p_perr_n_oe)
    else $error("data parity error pin not low two clocks after data");
  a_addr_refuse: assert property (bad_addr_s |=> !p_claim && st.status[0])
    else $error("bad address claimed or not flagged");
  a_addr_serr: assert property (bad_addr_s |=>
      p_serr_n_oe == st.ctrl[bridge_parity_pkg::P_SERR_BIT])
    else $error("system error does not follow its enable");
  a_serr_gate: assert property (s_serr_n_oe |-> $past(st.ctrl[bridge_parity_pkg::S_SERR_BIT]))
    else $error("secondary system error without enable");
  a_perr_park: assert property (p_txn_done && p_perr_n_oe && !perr_req[0] |=>
      p_perr_n_oe && p_perr_n_o ##1 !p_perr_n_oe)
    else $error("error pin not parked high for one clock");
  a_status_sticky: assert property (st.status[0] && !(reg_write && reg_addr ==
      bridge_parity_pkg::STATUS_OFS && reg_wdata[0]) |=> st.status[0])
    else $error("status bit lost without clear");
  a_irq_level: assert property (irq == |(st.status & st.mask))
    else $error("interrupt does not track masked status");
  a_par_gen: assert property (1'b1 |=> p_par_out == ($past(^{p_gen_ad, p_gen_cbe_n}) ^
      $past(p_gen_bad)))
    else $error("outgoing parity does not carry the queued condition");
  a_drop_write: assert property (p_data_valid && p_kind == bridge_parity_pkg::DS_DELAYED_WR &&
      st.ctrl[bridge_parity_pkg::P_RESP_BIT] ##1 (p_par != st.d_par) |=> p_drop)
    else $error("bad delayed write not dropped");
  a_cfg_rd_quiet: assert property (p_data_valid && p_kind == bridge_parity_pkg::CFG_RD |=>
      ##1 !p_chk_valid && p_perr_n_o)
    else $error("config read took a parity action");

endmodule

// file: rtl/bridge_parity_pkg.sv
package bridge_parity_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS   = 8'h08;

  // Control fields
  localparam int P_RESP_BIT = 0;  // primary parity_response_enable
  localparam int S_RESP_BIT = 1;  // secondary parity_response_enable
  localparam int P_SERR_BIT = 2;  // primary system error enable
  localparam int S_SERR_BIT = 3;  // secondary system error enable
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Status and mask fields; status bits sticky, write one to clear
  localparam int ST_P_DET   = 0;  // primary detected parity error
  localparam int ST_S_DET   = 1;  // secondary detected parity error
  localparam int ST_P_DPD   = 2;  // primary data parity detected
  localparam int ST_P_SERR  = 3;  // primary system error signalled
  localparam int ST_S_SERR  = 4;  // secondary system error signalled
  localparam int ST_P_PERR  = 5;  // primary data parity error signalled
  localparam int ST_S_PERR  = 6;  // secondary data parity error signalled
  localparam int ST_W       = 7;
  localparam logic [6:0] STATUS_RESET = 7'h00;
  localparam logic [6:0] MASK_RESET   = 7'h00;

  // Class of a data phase received on the primary bus
  typedef enum logic [2:0] {
    DS_POSTED_WR,
    DS_DELAYED_WR,
    DS_DELAYED_RD,
    US_DELAYED_RD,
    CFG_WR,
    CFG_RD
  } kind_t;

  // Whole state of the block
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [6:0]  status;
    logic [6:0]  mask;
    logic [31:0] rdata;
    logic [1:0]  a_pend;     // address phase awaiting its parity bit
    logic [1:0]  a_hit;
    logic [1:0]  a_par;      // computed address parity
    logic [1:0]  claim;
    logic [1:0]  serr;
    logic        d_pend;     // primary data phase awaiting parity
    logic        d_par;
    kind_t       d_kind;
    logic        d_multi;
    logic        chk_valid;
    logic        chk_bad;
    logic        drop;
    logic        stop_req;
    logic [1:0]  perr_low;
    logic [1:0]  perr_oe;
    logic [1:0]  perr_park;
    logic        s_perr_pend;
    logic [1:0]  par_out;
  } state_t;

endpackage

// file: sim/pci_agent.sv
`timescale 1ns/1ps
// Far-side bus agent: initiator phases with parity, target error reports
module pci_agent (
  input  wire logic        clock,
  output logic      [31:0] ad,
  output logic      [3:0]  cbe_n,
  output logic             par,
  output logic             perr_n_o,
  output logic             perr_n_oe
);
  // Idle: error pin released to its pull-up
  initial begin
    ad = 32'h0;
    cbe_n = 4'hF;
    par = 1'b0;
    perr_n_o = 1'b1;
    perr_n_oe = 1'b0;
  end

  // One phase; parity follows a clock later, stale lines are inverted
  task automatic phase(input logic [31:0] a, input logic [3:0] c, input logic bad);
    ad <= a;
    cbe_n <= c;
    @(posedge clock);
    par <= ^{a, c} ^ bad;
    ad <= ~a;
    cbe_n <= ~c;
  endtask

  // Target reports a write data error: low, high one clock, then released
  // Read data errors are handled by the bridge as initiator, never this agent
  task automatic report_perr;
    perr_n_o <= 1'b0;
    perr_n_oe <= 1'b1;
    @(posedge clock);
    perr_n_o <= 1'b1;
    fork
      begin
        @(posedge clock);
        perr_n_oe <= 1'b0;
      end
    join_none
  endtask
endmodule

// file: sim/bridge_parity_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the parity error response block
module bridge_parity_tb_top;
  logic                       clock, rst_n, reg_write, reg_read, irq, p_par, s_par;
  logic       [7:0]           reg_addr;
  logic       [31:0]          reg_wdata, reg_rdata, p_ad, s_ad, p_gen_ad, s_gen_ad, a, d;
  logic       [3:0]           p_cbe_n, s_cbe_n, p_gen_cbe_n, s_gen_cbe_n, c;
  logic                       p_addr_valid, p_hit, p_data_valid, p_multi, p_txn_done;
  logic                       p_us_posted, p_us_delayed, s_addr_valid, s_hit, s_txn_done;
  logic                       s_trdy_ret, s_err_seen, p_gen_bad, s_gen_bad, p_par_out, s_par_out;
  logic                       p_claim, s_claim, p_chk_valid, p_chk_bad, p_drop, p_stop_req;
  logic                       p_perr_n_o, p_perr_n_oe, s_perr_n_o, s_perr_n_oe, pe_o, pe_oe;
  logic                       p_serr_n_o, p_serr_n_oe, s_serr_n_o, s_serr_n_oe;
  logic                       bus, resp, sen, bad, m, chkd, rep, dr;
  wire                        p_perr_n_i;
  bridge_parity_pkg::kind_t   p_kind, k;
  int                         cycles, miscompares, tests_run;

  // Shared error wire: pull-up unless some agent drives it
  assign p_perr_n_i = (p_perr_n_oe ? p_perr_n_o : 1'b1) & (pe_oe ? pe_o : 1'b1);

  bridge_parity dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .irq, .p_ad, .p_cbe_n, .p_par, .p_addr_valid, .p_hit, .p_data_valid, .p_kind, .p_multi,
    .p_txn_done, .p_us_posted, .p_us_delayed, .p_perr_n_i, .s_ad, .s_cbe_n, .s_par,
    .s_addr_valid, .s_hit, .s_txn_done, .s_trdy_ret, .s_err_seen, .p_gen_ad, .p_gen_cbe_n,
    .p_gen_bad, .s_gen_ad, .s_gen_cbe_n, .s_gen_bad, .p_par_out, .s_par_out, .p_claim,
    .s_claim, .p_chk_valid, .p_chk_bad, .p_drop, .p_stop_req, .p_perr_n_o, .p_perr_n_oe,
    .s_perr_n_o, .s_perr_n_oe, .p_serr_n_o, .p_serr_n_oe, .s_serr_n_o, .s_serr_n_oe);
  pci_agent pa (.clock, .ad(p_ad), .cbe_n(p_cbe_n), .par(p_par), .perr_n_o(pe_o),
    .perr_n_oe(pe_oe));
  pci_agent sa (.clock, .ad(s_ad), .cbe_n(s_cbe_n), .par(s_par), .perr_n_o(), .perr_n_oe());

  // 250 MHz clock
  always #2 clock = ~clock;

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      stop_test;
    end
  end

  task automatic stop_test;
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Register writes and reads, one-cycle strobes
  task automatic reg_wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Main sequence
  initial begin
    {reg_addr, reg_wdata, reg_write, reg_read, p_addr_valid, p_hit, p_data_valid, p_multi,
     p_txn_done, p_us_posted, p_us_delayed, s_addr_valid, s_hit, s_txn_done, s_trdy_ret,
     s_err_seen, p_gen_ad, p_gen_cbe_n, p_gen_bad, s_gen_ad, s_gen_cbe_n, s_gen_bad} = '0;
    p_kind = bridge_parity_pkg::DS_POSTED_WR;
    clock = 1'b0;
    rst_n = 1'b0;
    void'($urandom(11));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values, unmapped address reads zero
    for (int i = 0; i < 4; i++) begin
      reg_rd(8'(i * 4), d);
      chk("reg_reset", 32'h0, d);
    end
    // Outgoing parity carries the queued bad flag on both buses
    repeat (8) begin
      @(posedge clock);
      a = $urandom;
      c = 4'($urandom);
      bad = 1'($urandom);
      p_gen_ad <= a;
      p_gen_cbe_n <= c;
      p_gen_bad <= bad;
      s_gen_ad <= ~a;
      s_gen_cbe_n <= c;
      s_gen_bad <= !bad;
      @(posedge clock);
      #1 chk("p_par_out", 32'(^{a, c} ^ bad), 32'(p_par_out));
      chk("s_par_out", 32'(^{~a, c} ^ !bad), 32'(s_par_out));
    end
    // Address phases: every bus, response and system error enable setting
    for (int i = 0; i < 16; i++) begin
      {bad, sen, resp, bus} = 4'(i);
      reg_wr(bridge_parity_pkg::CTRL_OFS, {28'h0, sen, sen, resp, resp});
      reg_wr(bridge_parity_pkg::STATUS_OFS, 32'h7F);
      @(posedge clock);
      if (bus) begin
        s_addr_valid <= 1'b1;
        s_hit <= 1'b1;
        sa.phase($urandom, 4'($urandom), bad);
        s_addr_valid <= 1'b0;
      end else begin
        p_addr_valid <= 1'b1;
        p_hit <= 1'b1;
        pa.phase($urandom, 4'($urandom), bad);
        p_addr_valid <= 1'b0;
      end
      @(posedge clock);
      #1 chk("claim", 32'(!(bad && resp)), 32'(bus ? s_claim : p_claim));
      chk("serr_oe", 32'(bad && resp && sen), 32'(bus ? s_serr_n_oe : p_serr_n_oe));
      reg_rd(bridge_parity_pkg::STATUS_OFS, d);
      chk("addr_det", 32'(bad), 32'(d[bus]));
    end
    // Primary data phases with bad parity, every class, response off and on
    for (int i = 0; i < 12; i++) begin
      k = bridge_parity_pkg::kind_t'(i / 2);
      resp = i[0];
      m = 1'($urandom);
      reg_wr(bridge_parity_pkg::CTRL_OFS, 32'(resp));
      reg_wr(bridge_parity_pkg::STATUS_OFS, 32'h7F);
      @(posedge clock);
      p_data_valid <= 1'b1;
      p_kind <= k;
      p_multi <= m;
      pa.phase($urandom, 4'($urandom), 1'b1);
      p_data_valid <= 1'b0;
      chkd = k != bridge_parity_pkg::DS_DELAYED_RD && k != bridge_parity_pkg::CFG_RD;
      rep = chkd && resp;
      dr = resp && k == bridge_parity_pkg::DS_DELAYED_WR;
      @(posedge clock);
      #1 chk("chk", {30'h0, chkd, chkd}, {30'h0, p_chk_valid, p_chk_bad});
      chk("perr_low", {30'h0, rep, !rep}, {30'h0, p_perr_n_oe, p_perr_n_o});
      chk("drop", {30'h0, dr, dr && m}, {30'h0, p_drop, p_stop_req});
      @(posedge clock);
      p_txn_done <= 1'b1;
      @(posedge clock);
      p_txn_done <= 1'b0;
      #1 chk("perr_park", {30'h0, rep, 1'b1}, {30'h0, p_perr_n_oe, p_perr_n_o});
      @(posedge clock);
      #1 chk("perr_free", 32'h0, 32'(p_perr_n_oe));
      reg_rd(bridge_parity_pkg::STATUS_OFS, d);
      chk("data_status", {29'h0, resp && k == bridge_parity_pkg::US_DELAYED_RD, 1'b0, chkd},
          {29'h0, d[2:0]});
    end
    // Upstream posted write, target reports an error; secondary error blocks the pulse
    for (int j = 0; j < 2; j++) begin
      reg_wr(bridge_parity_pkg::CTRL_OFS, 32'hB);
      reg_wr(bridge_parity_pkg::STATUS_OFS, 32'h7F);
      @(posedge clock);
      p_us_posted <= 1'b1;
      s_err_seen <= j[0];
      pa.report_perr;
      p_us_posted <= 1'b0;
      #1 chk("us_serr", 32'(!j[0]), 32'(s_serr_n_oe));
      reg_rd(bridge_parity_pkg::STATUS_OFS, d);
      chk("us_dpd", 32'h1, 32'(d[2]));
    end
    // Upstream delayed write: error shown with secondary ready, then parked
    reg_wr(bridge_parity_pkg::CTRL_OFS, 32'h3);
    reg_wr(bridge_parity_pkg::STATUS_OFS, 32'h7F);
    @(posedge clock);
    p_us_delayed <= 1'b1;
    pa.report_perr;
    p_us_delayed <= 1'b0;
    @(posedge clock);
    s_trdy_ret <= 1'b1;
    @(posedge clock);
    s_trdy_ret <= 1'b0;
    #1 chk("s_perr", 32'h2, {30'h0, s_perr_n_oe, s_perr_n_o});
    @(posedge clock);
    s_txn_done <= 1'b1;
    @(posedge clock);
    s_txn_done <= 1'b0;
    #1 chk("s_park", 32'h3, {30'h0, s_perr_n_oe, s_perr_n_o});
    // Sticky status, mask and write-one-to-clear through the interrupt
    chk("irq_masked", 32'h0, 32'(irq));
    reg_wr(bridge_parity_pkg::MASK_OFS, 32'h40);
    #1 chk("irq_on", 32'h1, 32'(irq));
    // Clear every bit except the two just set, which must survive
    reg_wr(bridge_parity_pkg::STATUS_OFS, 32'h3B);
    reg_rd(bridge_parity_pkg::STATUS_OFS, d);
    chk("sticky", 32'h44, d);
    reg_wr(bridge_parity_pkg::STATUS_OFS, 32'h40);
    #1 chk("irq_off", 32'h0, 32'(irq));
    stop_test;
  end
endmodule
